//--- hw/acd_detector.sv
/*
  Audio clock detector and status registers: measures bit clocks per frame,
  watches the system, frame and bit clock pins and reports the flags.
  Assumes the pins are asynchronous to clk; the aux status comes from logic
  on clk; the register port is a simple strobe port on clk.
*/
`timescale 1ns/100ps
module acd_detector (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_clock,
  input wire logic bit_clock,
  input wire logic sys_clock,
  input wire acd_pkg::acd_aux_t aux,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] pin_m_q;
  logic [2:0] pin_s_q;
  logic [2:0] pin_p_q;
  logic [2:0] pin_m_d;
  logic [2:0] pin_s_d;
  logic [2:0] pin_p_d;

  always_comb begin
    pin_m_d = {sys_clock, bit_clock, frame_clock};
    pin_s_d = pin_m_q;
    pin_p_d = pin_s_q;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pin_m_q <= 3'h0;
      pin_s_q <= 3'h0;
      pin_p_q <= 3'h0;
    end else begin
      pin_m_q <= pin_m_d;
      pin_s_q <= pin_s_d;
      pin_p_q <= pin_p_d;
    end
  end

  logic fclk;
  logic bclk;
  logic fclk_rise;
  logic bclk_rise;
  logic sclk_edge;

  assign fclk = pin_s_q[0];
  assign bclk = pin_s_q[1];
  assign fclk_rise = pin_s_q[0] & ~pin_p_q[0];
  assign bclk_rise = pin_s_q[1] & ~pin_p_q[1];
  assign sclk_edge = pin_s_q[2] ^ pin_p_q[2];

  function automatic logic [acd_pkg::TMR_W-1:0] tmr_step(
    input logic [acd_pkg::TMR_W-1:0] cnt,
    input logic restart,
    input int limit
  );
    if (restart) begin
      tmr_step = '0;
    end else if (cnt >= acd_pkg::TMR_W'(limit)) begin
      tmr_step = cnt;
    end else begin
      tmr_step = cnt + acd_pkg::TMR_W'(1);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // quiet timers for the system clock and the frame and bit clocks

  logic [acd_pkg::TMR_W-1:0] sclk_tmr_q;
  logic [acd_pkg::TMR_W-1:0] sclk_tmr_d;
  logic [acd_pkg::TMR_W-1:0] link_tmr_q;
  logic [acd_pkg::TMR_W-1:0] link_tmr_d;
  logic sysclk_halted;
  logic link_absent;

  always_comb begin
    sclk_tmr_d = tmr_step(sclk_tmr_q, sclk_edge, acd_pkg::SYSCLK_HALT_CYC);
    // any high level restarts it: missing means both held low
    link_tmr_d = tmr_step(link_tmr_q, fclk | bclk, acd_pkg::LINK_MISS_CYC);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sclk_tmr_q <= '0;
      link_tmr_q <= '0;
    end else begin
      sclk_tmr_q <= sclk_tmr_d;
      link_tmr_q <= link_tmr_d;
    end
  end

  assign sysclk_halted = (sclk_tmr_q >= acd_pkg::TMR_W'(acd_pkg::SYSCLK_HALT_CYC));
  assign link_absent = (link_tmr_q >= acd_pkg::TMR_W'(acd_pkg::LINK_MISS_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // bit clocks per frame measurement

  function automatic logic [8:0] sat_inc9(input logic [8:0] v);
    sat_inc9 = (v == 9'h1ff) ? v : v + 9'h001;
  endfunction

  acd_pkg::acd_meas_t meas_q;
  acd_pkg::acd_meas_t meas_d;
  logic [8:0] bcnt_q;
  logic [8:0] bcnt_d;
  logic [3:0] lcnt_q;
  logic [3:0] lcnt_d;
  logic [8:0] ratio_q;
  logic [8:0] ratio_d;
  logic stable_q;
  logic stable_d;
  logic short_low_q;
  logic short_low_d;

  always_comb begin
    meas_d = meas_q;
    bcnt_d = bcnt_q;
    lcnt_d = lcnt_q;
    ratio_d = ratio_q;
    stable_d = stable_q;
    short_low_d = short_low_q;
    case (meas_q)
      acd_pkg::MEAS_WAIT: begin
        if (fclk_rise) begin
          meas_d = acd_pkg::MEAS_RUN;
          bcnt_d = '0;
          lcnt_d = '0;
        end
      end
      acd_pkg::MEAS_RUN: begin
        if (link_absent) begin
          meas_d = acd_pkg::MEAS_WAIT;
          stable_d = 1'b0;
        end else if (fclk_rise) begin
          // whole frame seen: publish both halves at once
          ratio_d = bcnt_q;
          stable_d = (bcnt_q == ratio_q);
          // low phase of five bit clocks or fewer
          short_low_d = (lcnt_q <= acd_pkg::SHORT_LOW_MAX);
          bcnt_d = bclk_rise ? 9'h001 : 9'h000;
          lcnt_d = '0;
        end else if (bclk_rise) begin
          bcnt_d = sat_inc9(bcnt_q);
          if (!fclk && lcnt_q != 4'hf) begin
            lcnt_d = lcnt_q + 4'h1;
          end
        end
      end
      default: begin
        meas_d = acd_pkg::MEAS_WAIT;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meas_q <= acd_pkg::MEAS_WAIT;
      bcnt_q <= '0;
      lcnt_q <= '0;
      ratio_q <= acd_pkg::RATIO_RESET;
      stable_q <= 1'b0;
      short_low_q <= 1'b0;
    end else begin
      meas_q <= meas_d;
      bcnt_q <= bcnt_d;
      lcnt_q <= lcnt_d;
      ratio_q <= ratio_d;
      stable_q <= stable_d;
      short_low_q <= short_low_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // detector flags

  acd_pkg::acd_det_t det;
  logic ratio_in_range;

  // a one-per-frame count is not trusted, the range check rejects it
  assign ratio_in_range = (ratio_q >= acd_pkg::RATIO_MIN) && (ratio_q <= acd_pkg::RATIO_MAX);

  always_comb begin
    det.sysclk_halted = sysclk_halted;
    det.pll_unlocked = ~(aux.pll_locked & aux.pll_enabled);
    det.link_absent = link_absent;
    det.autoset_error = ~aux.autoset_ok;
    det.sysclk_invalid = ~aux.sysclk_ratio_ok | short_low_q | sysclk_halted;
    det.bitclk_invalid = ~(stable_q & ratio_in_range) | link_absent;
    det.rate_invalid = ~aux.rate_ok & ~aux.ignore_errors;
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched halt flag

  logic halt_latch_q;
  logic halt_latch_d;
  logic evt_read;

  assign evt_read = reg_rd && (reg_addr == acd_pkg::OFF_EVT_FLAGS);

  always_comb begin
    // a halt in the cycle of the read wins over the clear
    if (sysclk_halted) begin
      halt_latch_d = 1'b1;
    end else if (evt_read) begin
      halt_latch_d = 1'b0;
    end else begin
      halt_latch_d = halt_latch_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      halt_latch_q <= 1'b0;
    end else begin
      halt_latch_q <= halt_latch_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port; all four registers are read only

  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [7:0] evt_flags;

  always_comb begin
    evt_flags = 8'h00;
    evt_flags[acd_pkg::POS_LATCHED_HALT] = halt_latch_q;
    evt_flags[acd_pkg::POS_CLOCKS_ABSENT] = link_absent;
    evt_flags[acd_pkg::POS_RESYNC] = aux.resync_busy;
    evt_flags[acd_pkg::POS_CLOCK_ERROR] = |det;
  end

  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = reg_rd;
    // writes are ignored; reserved bits read zero
    if (reg_rd) begin
      case (reg_addr)
        acd_pkg::OFF_RATIO_HIGH: rdata_d = {7'h00, ratio_q[acd_pkg::RATIO_W-1]};
        acd_pkg::OFF_RATIO_LOW: rdata_d = ratio_q[7:0];
        acd_pkg::OFF_DET_FLAGS: rdata_d = {1'b0, det};
        acd_pkg::OFF_EVT_FLAGS: rdata_d = evt_flags;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_q <= acd_pkg::RDATA_RESET;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;

  logic unused_wr;
  assign unused_wr = reg_wr ^ (|reg_wdata);

endmodule

//--- hw/acd_pkg.sv
/*
  Package of the audio clock detector: register offsets, field positions,
  reset values, timing counts and the carrier types of the status flags.
  Assumes a 100 MHz block clock and a register port on the same clock.
*/
// Operation
// - top bit of the nine-bit bit-clocks-per-frame count reads at 0x5c bit 0.
// - low byte of the count reads at 0x5d; writes leave it unchanged.
// - a count at one bit clock per frame is unreliable; software ignores it.
// - 0x5e bit 6 is high while the system clock is halted.
// - 0x5e bit 5 is high when the pll is unlocked or disabled.
// - 0x5e bit 4 is high only while frame and bit clocks both sit low.
// - 0x5e bit 3 is high when rate and system clock ratio forbid auto set.
// - 0x5e bit 2 flags undetectable system clock ratio or frame low phase of five or less.
// - 0x5e bit 1 flags a bit clock ratio unstable or outside 32 to 256.
// - 0x5e bit 0 flags an undetectable sample rate.
// - the sample rate flag drops while all errors are ignored.
// - 0x5f bit 4 latches any system clock halt; reading 0x5f clears it.
// - 0x5f bit 2 is high while frame and bit clocks are both missing.
// - 0x5f bit 1 is high while a clock resync is in progress.
// - 0x5f bit 0 is high while any clock error is reported.
package acd_pkg;

  localparam logic [7:0] OFF_RATIO_HIGH = 8'h5c;
  localparam logic [7:0] OFF_RATIO_LOW = 8'h5d;
  localparam logic [7:0] OFF_DET_FLAGS = 8'h5e;
  localparam logic [7:0] OFF_EVT_FLAGS = 8'h5f;

  localparam int RATIO_W = 9;
  localparam int POS_RATIO_TOP = 0;
  localparam int POS_LATCHED_HALT = 4;
  localparam int POS_CLOCKS_ABSENT = 2;
  localparam int POS_RESYNC = 1;
  localparam int POS_CLOCK_ERROR = 0;

  localparam logic [8:0] RATIO_MIN = 9'h020;
  localparam logic [8:0] RATIO_MAX = 9'h100;
  localparam logic [3:0] SHORT_LOW_MAX = 4'h5;
  localparam logic [8:0] RATIO_RESET = 9'h000;
  localparam logic [7:0] RDATA_RESET = 8'h00;

  localparam int CLK_MHZ = 100;
  // longest quiet time on the system clock pin before it counts as halted
  localparam int SYSCLK_HALT_NS = 1000;
  localparam int SYSCLK_HALT_CYC = (SYSCLK_HALT_NS * CLK_MHZ + 999) / 1000;
  // longest quiet time on frame and bit clocks before they count as missing
  localparam int LINK_MISS_NS = 4000;
  localparam int LINK_MISS_CYC = (LINK_MISS_NS * CLK_MHZ + 999) / 1000;
  localparam int TMR_W = 12;

  typedef enum logic [1:0] {
    MEAS_WAIT = 2'b01,
    MEAS_RUN = 2'b10
  } acd_meas_t;

  // clock detector flags, bit 6 down to bit 0
  typedef struct packed {
    logic sysclk_halted;
    logic pll_unlocked;
    logic link_absent;
    logic autoset_error;
    logic sysclk_invalid;
    logic bitclk_invalid;
    logic rate_invalid;
  } acd_det_t;

  // status inputs from the neighbouring rate and ratio detectors
  typedef struct packed {
    logic pll_locked;
    logic pll_enabled;
    logic autoset_ok;
    logic sysclk_ratio_ok;
    logic rate_ok;
    logic ignore_errors;
    logic resync_busy;
  } acd_aux_t;

endpackage

//--- tb/acd_asserts.sv
/*
  Checker of the clock detector register port.
  Assumes a bind onto acd_detector, all ports but the frame, bit and system clock pins on clk.
*/
`timescale 1ns/100ps
module acd_asserts (
  input wire logic clk,
  input wire logic reset,
  input wire logic frame_clock,
  input wire logic bit_clock,
  input wire logic sys_clock,
  input wire acd_pkg::acd_aux_t aux,
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////
  rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read not answered");
  no_stray_a: assert property (!reg_rd |=> !reg_rvalid) else $error("stray read answer");
  data_hold_a: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  pll_flag_a: assert property (reg_rd && reg_addr == 8'h5e |=>
    reg_rdata[5] == !$past(aux.pll_locked && aux.pll_enabled)) else $error("pll flag wrong");
  autoset_flag_a: assert property (reg_rd && reg_addr == 8'h5e |=>
    reg_rdata[3] == !$past(aux.autoset_ok)) else $error("autoset flag wrong");
  rate_flag_a: assert property (reg_rd && reg_addr == 8'h5e |=>
    reg_rdata[0] == $past(!aux.rate_ok && !aux.ignore_errors)) else $error("rate flag wrong");
  resync_flag_a: assert property (reg_rd && reg_addr == 8'h5f |=>
    reg_rdata[1] == $past(aux.resync_busy)) else $error("resync flag wrong");
  error_flag_a: assert property (reg_rd && reg_addr == 8'h5f && !aux.autoset_ok |=>
    reg_rdata[0]) else $error("clock error missing");
  ratio_top_a: assert property (reg_rd && reg_addr == 8'h5c |=>
    reg_rdata[7:1] == 7'h00) else $error("ratio high spare bits set");
  unmapped_a: assert property (reg_rd && (reg_addr < 8'h5c || reg_addr > 8'h5f) |=>
    reg_rdata == 8'h00) else $error("unmapped read not zero");
endmodule

//--- tb/acd_detector_bench.sv
/*
  Testbench of the audio clock detector with a link source model.
  Assumes acd_detector, acd_link_model and acd_asserts compiled first.
*/
`timescale 1ns/100ps
module acd_detector_bench;
  logic clk, reset, run, sck_run, reg_rd, reg_wr, reg_rvalid, frame_clock, bit_clock, sys_clock;
  logic [8:0] n_bits, lo_bits;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, a, b;
  acd_pkg::acd_aux_t aux;
  int failures = 0;
  int n_compared = 0;
  acd_detector acd_detector_i (.clk, .reset, .frame_clock, .bit_clock, .sys_clock, .aux, .reg_addr,
    .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid);
  acd_link_model acd_link_model_i (.run, .sck_run, .n_bits, .lo_bits, .frame_clock, .bit_clock, .sys_clock);
  ////////////////////////////////////////////////////////////
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] addr, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= addr;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rvalid, 1'b1);
    d = reg_rdata;
  endtask
  task automatic frames(input logic [8:0] n, input logic [8:0] lo);
    n_bits <= n;
    lo_bits <= lo;
    repeat (3) @(posedge frame_clock);
    repeat (10) @(posedge clk);
  endtask
  task automatic give_verdict();
    if (failures == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  // range edges of the ratio, with a write that must not land
  task automatic t_ratio();
    logic [8:0] tbl [4] = '{9'h01f, 9'h020, 9'h100, 9'h12c};
    for (int k = 0; k < 4; k++) begin
      frames(tbl[k], tbl[k] >> 1);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 8'h5d;
      reg_wdata <= 8'h5a; // defined bits only
      @(posedge clk);
      reg_wr <= 1'b0;
      rd(8'h5c, a);
      rd(8'h5d, b);
      chk({a[0], b}, tbl[k]);
      rd(8'h5e, a);
      chk(a[1], tbl[k] < 9'h020 || tbl[k] > 9'h100);
      chk(a[4], 1'b0);
      chk(a[6], 1'b0);
    end
  endtask
  task automatic t_short();
    for (int lo = 5; lo < 7; lo++) begin
      frames(9'h040, 9'(lo));
      rd(8'h5e, a);
      chk(a[2], lo == 5);
    end
  endtask
  task automatic t_aux();
    for (int v = 0; v < 128; v++) begin
      @(posedge clk);
      aux <= v[6:0];
      rd(8'h5e, a);
      rd(8'h5f, b);
      chk(a[5], !(aux.pll_locked && aux.pll_enabled));
      chk(a[3], !aux.autoset_ok);
      chk(a[2], !aux.sysclk_ratio_ok);
      chk(a[0], !aux.rate_ok && !aux.ignore_errors);
      chk(b, {6'h00, aux.resync_busy, |a[6:0]});
    end
    @(posedge clk);
    aux <= 7'h7c;
  endtask
  task automatic t_absent();
    run <= 1'b0;
    repeat (450) @(posedge clk);
    rd(8'h5e, a);
    rd(8'h5f, b);
    chk({a[4], a[1], b[2], b[0]}, 4'hf);
    sck_run <= 1'b0;
    repeat (150) @(posedge clk);
    rd(8'h5e, a);
    chk(a[6], 1'b1);
    // a read while still halted must not clear the latch
    rd(8'h5f, a);
    rd(8'h5f, b);
    chk({a[4], b[4]}, 2'b11);
    sck_run <= 1'b1;
    repeat (20) @(posedge clk);
    rd(8'h5f, a);
    rd(8'h5f, b);
    chk({a[4], b[4]}, 2'b10);
    run <= 1'b1;
  endtask
  // mid-run reset: no frame measured yet, so the count reads zero
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    rd(8'h5c, a);
    rd(8'h5d, b);
    chk({a[0], b}, 9'h000);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  initial begin
    #800000;
    failures++;
    give_verdict();
  end
  initial begin
    reset = 1'b1;
    run = 1'b1;
    sck_run = 1'b1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    n_bits = 9'h040;
    lo_bits = 9'h020;
    aux = 7'h7c;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    t_ratio();
    t_short();
    t_aux();
    t_absent();
    t_reset();
    rd(8'h60, a);
    chk(a, 9'h000);
    give_verdict();
  end
endmodule
bind acd_detector acd_asserts acd_asserts_i (.clk, .reset, .frame_clock, .bit_clock, .sys_clock, .aux,
  .reg_addr, .reg_rd, .reg_wr, .reg_wdata, .reg_rdata, .reg_rvalid);

//--- tb/acd_link_model.sv
/*
  Audio source model making frame, bit and system clocks.
  Assumes the bench sets frame length and low phase in bit clocks.
*/
`timescale 1ns/100ps
module acd_link_model (
  input wire logic run,
  input wire logic sck_run,
  input wire logic [8:0] n_bits,
  input wire logic [8:0] lo_bits,
  output logic frame_clock,
  output logic bit_clock,
  output logic sys_clock
);
  int i;
  ////////////////////////////////////////////////////////////
  // stopped frame and bit clocks sit low; a stopped system clock holds its last level
  initial begin
    sys_clock = 1'b0;
    forever #20 if (sck_run) sys_clock = !sys_clock;
  end
  initial begin
    forever begin
      frame_clock = 1'b0;
      bit_clock = 1'b0;
      #80;
      for (i = 0; i < n_bits && run; i++) begin
        frame_clock = (i < n_bits - lo_bits);
        bit_clock = 1'b0;
        #80;
        bit_clock = 1'b1;
        #80;
      end
    end
  end
endmodule
